// File: core/pmsw_core.sv
// Automatic P versus PI switching of the speed loop.
// Assumes loop quantities and update strobe on ref_clk, from the loops.
`timescale 1ns/10ps
`include "pmsw_defines.svh"

module pmsw_core (
  input wire logic ref_clk,
  input wire logic rst,
  input wire pmsw_pkg::pmsw_bus_t bus,
  output logic [15:0] rdata,
  input wire pmsw_pkg::pmsw_loop_t loop_in,
  output logic p_only
);
  import pmsw_pkg::*;

  pmsw_state_t st_r;
  pmsw_state_t st_nxt;
  logic [3:0] over;
  logic [3:0][15:0] qty;
  logic sel_over;

  // Quantities in selector order
  assign qty[0] = loop_in.torque;
  assign qty[1] = loop_in.speed;
  assign qty[2] = loop_in.accel;
  assign qty[3] = loop_in.poserr;

  // One comparator per detection quantity
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_cmp
      pmsw_level_cmp u_cmp (
        .value(qty[g]),
        .level(st_r.lvl[g]),
        .exceeds(over[g])
      );
    end
  endgenerate

  // Condition of the selected quantity
  always_comb begin
    case (st_r.sel)
      `PMSW_SEL_TRQ: sel_over = over[0];
      `PMSW_SEL_SPD: sel_over = over[1];
      `PMSW_SEL_ACC: sel_over = over[2];
      `PMSW_SEL_PER: sel_over = over[3] & loop_in.pos_mode;
      default: sel_over = 1'b0;
    endcase
  end

  // Saturate a written level to its channel limit
  function automatic logic [15:0] clamp_lvl(input logic [1:0] ch,
                                            input logic [15:0] v);
    logic [15:0] lim;
    case (ch)
      2'h0: lim = `PMSW_MAX_TRQ;
      2'h1: lim = `PMSW_MAX_SPD;
      2'h2: lim = `PMSW_MAX_ACC;
      default: lim = `PMSW_MAX_PER;
    endcase
    clamp_lvl = (v > lim) ? lim : v;
  endfunction : clamp_lvl

  // Next state: register writes, reads and the loop-rate decision
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 16'h0000;
    if (bus.wr) begin
      case (bus.addr)
        `PMSW_OFS_SEL: st_nxt.sel = bus.wdata[2:0];
        `PMSW_OFS_TRQ: st_nxt.lvl[0] = clamp_lvl(2'h0, bus.wdata);
        `PMSW_OFS_SPD: st_nxt.lvl[1] = clamp_lvl(2'h1, bus.wdata);
        `PMSW_OFS_ACC: st_nxt.lvl[2] = clamp_lvl(2'h2, bus.wdata);
        `PMSW_OFS_PER: st_nxt.lvl[3] = clamp_lvl(2'h3, bus.wdata);
        default: ;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        `PMSW_OFS_SEL: st_nxt.rdata = {13'h0000, st_r.sel};
        `PMSW_OFS_TRQ: st_nxt.rdata = st_r.lvl[0];
        `PMSW_OFS_SPD: st_nxt.rdata = st_r.lvl[1];
        `PMSW_OFS_ACC: st_nxt.rdata = st_r.lvl[2];
        `PMSW_OFS_PER: st_nxt.rdata = st_r.lvl[3];
        `PMSW_OFS_STAT: begin
          st_nxt.rdata[`PMSW_STAT_PONLY] = st_r.p_only;
          st_nxt.rdata[`PMSW_STAT_OVER] = sel_over;
        end
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
    // P when the selected quantity passes its level (position error only with pos_mode set), else PI
    if (loop_in.update) begin
      st_nxt.p_only = sel_over;
    end
  end

  // State register with factory values at reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r.sel <= `PMSW_RST_SEL;
      st_r.lvl[0] <= `PMSW_RST_TRQ;
      st_r.lvl[1] <= `PMSW_RST_SPD;
      st_r.lvl[2] <= `PMSW_RST_ACC;
      st_r.lvl[3] <= `PMSW_RST_PER;
      st_r.p_only <= 1'b0;
      st_r.rdata <= 16'h0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign p_only = st_r.p_only;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_sel_read;
    bus.rd && !bus.wr && bus.addr == `PMSW_OFS_SEL;
  endsequence

  sequence s_upd_sel(logic [2:0] code);
    loop_in.update && st_r.sel == code;
  endsequence

  a_disabled_stays_pi: assert property (
    s_upd_sel(`PMSW_SEL_OFF) |=> !p_only)
    else $error("switching active while disabled");

  a_torque_forces_p: assert property (
    s_upd_sel(`PMSW_SEL_TRQ) ##0 over[0] |=> p_only)
    else $error("torque over level did not force P");

  a_speed_forces_p: assert property (
    s_upd_sel(`PMSW_SEL_SPD) ##0 over[1] |=> p_only)
    else $error("speed over level did not force P");

  a_accel_forces_p: assert property (
    s_upd_sel(`PMSW_SEL_ACC) ##0 over[2] |=> p_only)
    else $error("acceleration over level did not force P");

  a_poserr_forces_p: assert property (
    s_upd_sel(`PMSW_SEL_PER) ##0 (over[3] && loop_in.pos_mode) |=> p_only)
    else $error("position error over level did not force P");

  a_poserr_needs_pos: assert property (
    s_upd_sel(`PMSW_SEL_PER) ##0 !loop_in.pos_mode |=> !p_only)
    else $error("position error switched outside position control");

  a_below_level_pi: assert property (
    loop_in.update && !over[st_r.sel[1:0]] |=> !p_only)
    else $error("PI not kept below level");

  a_hold_between: assert property (
    !loop_in.update |=> $stable(p_only))
    else $error("P/PI changed without loop update");

  a_sel_readback: assert property (
    s_sel_read |=> rdata == {13'h0000, $past(st_r.sel)})
    else $error("selector read back wrong");

  a_trq_limit: assert property (
    st_r.lvl[0] <= `PMSW_MAX_TRQ)
    else $error("torque level above limit");

  a_spd_limit: assert property (
    st_r.lvl[1] <= `PMSW_MAX_SPD)
    else $error("speed level above limit");

  a_acc_limit: assert property (
    st_r.lvl[2] <= `PMSW_MAX_ACC)
    else $error("acceleration level above limit");

  a_per_limit: assert property (
    st_r.lvl[3] <= `PMSW_MAX_PER)
    else $error("position error level above limit");

  // Oversized torque writes land at the limit, not wrapped
  a_trq_saturate: assert property (
    bus.wr && bus.addr == `PMSW_OFS_TRQ && bus.wdata > `PMSW_MAX_TRQ
    |=> st_r.lvl[0] == `PMSW_MAX_TRQ)
    else $error("torque level write not saturated");

  // Single read strobe at a given offset
  sequence s_read_at(logic [3:0] ofs);
    bus.rd && !bus.wr && bus.addr == ofs;
  endsequence

  a_trq_readback: assert property (
    s_read_at(`PMSW_OFS_TRQ) |=> rdata == $past(st_r.lvl[0]))
    else $error("torque level read back wrong");

  // Status shows the decision and the live condition of the read cycle
  a_stat_readback: assert property (
    s_read_at(`PMSW_OFS_STAT)
    |=> rdata == {14'h0000, $past(sel_over), $past(p_only)})
    else $error("status read back wrong");

  a_rdata_idle: assert property (
    !bus.rd |=> rdata == 16'h0000)
    else $error("read data not zero outside a read");

  a_sel_write: assert property (
    bus.wr && bus.addr == `PMSW_OFS_SEL
    |=> st_r.sel == $past(bus.wdata[2:0]))
    else $error("selector write did not land");

  // Codes 4 and above all leave the loop in PI
  a_high_codes_off: assert property (
    loop_in.update && st_r.sel[2] |=> !p_only)
    else $error("switching active with selector code 4 or above");

  a_update_follows: assert property (
    loop_in.update |=> p_only == $past(sel_over))
    else $error("P/PI state does not follow the selected condition");

endmodule : pmsw_core

// File: core/pmsw_defines.svh
// Register offsets, reset values and setting limits of the P/PI switch.
// Assumes inclusion by bare name from the package and the core module.
`ifndef PMSW_DEFINES_SVH
`define PMSW_DEFINES_SVH

// Register offsets on the plain register port
`define PMSW_OFS_SEL 4'h0
`define PMSW_OFS_TRQ 4'h1
`define PMSW_OFS_SPD 4'h2
`define PMSW_OFS_ACC 4'h3
`define PMSW_OFS_PER 4'h4
`define PMSW_OFS_STAT 4'h5

// Selector codes
`define PMSW_SEL_TRQ 3'h0
`define PMSW_SEL_SPD 3'h1
`define PMSW_SEL_ACC 3'h2
`define PMSW_SEL_PER 3'h3
`define PMSW_SEL_OFF 3'h4

// Reset values after factory initialization
`define PMSW_RST_SEL 3'h0
`define PMSW_RST_TRQ 16'h00C8
`define PMSW_RST_SPD 16'h0000
`define PMSW_RST_ACC 16'h0000
`define PMSW_RST_PER 16'h0000

// Upper limits of each level setting
`define PMSW_MAX_TRQ 16'h0320
`define PMSW_MAX_SPD 16'h2710
`define PMSW_MAX_ACC 16'h7530
`define PMSW_MAX_PER 16'h2710

// Status field positions
`define PMSW_STAT_PONLY 0
`define PMSW_STAT_OVER 1

`endif

// File: core/pmsw_pkg.sv
// Types shared by the P/PI switch core and its testbench.
// Assumes the defines header sits beside this file.
`include "pmsw_defines.svh"

package pmsw_pkg;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } pmsw_bus_t;

  // Quantities from the control loops, two's complement
  typedef struct packed {
    logic [15:0] torque;
    logic [15:0] speed;
    logic [15:0] accel;
    logic [15:0] poserr;
    logic pos_mode;
    logic update;
  } pmsw_loop_t;

  // Whole state of the core
  typedef struct packed {
    logic [2:0] sel;
    logic [3:0][15:0] lvl;
    logic p_only;
    logic [15:0] rdata;
  } pmsw_state_t;

endpackage : pmsw_pkg

// File: core/pmsw_level_cmp.sv
// Magnitude comparator: flags a signed quantity whose size passes a level.
// Assumes a level no larger than 15 bits; purely combinational.
`timescale 1ns/10ps

module pmsw_level_cmp (
  input wire logic [15:0] value,
  input wire logic [15:0] level,
  output logic exceeds
);

  logic signed [16:0] ext;
  logic [16:0] mag;

  // Absolute value kept one bit wider so the most negative input fits
  always_comb begin
    ext = {value[15], value};
    mag = ext[16] ? 17'(-ext) : 17'(ext);
    exceeds = mag > {1'b0, level};
  end

endmodule : pmsw_level_cmp

// File: bench/pmsw_core_tb.sv
// Self-checking bench for the P/PI switching core.
// Drives the register port and loop inputs itself; one clock domain.
`timescale 1ns/10ps

module pmsw_core_tb;
  import pmsw_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  pmsw_bus_t bus = '0;
  pmsw_loop_t loop_in = '0;
  logic [15:0] rdata;
  logic p_only;
  int failures = 0;
  int tests_run = 0;

  // Clock at 10 MHz
  always #50 ref_clk = ~ref_clk;

  pmsw_core dut_u (
    .ref_clk(ref_clk),
    .rst(rst),
    .bus(bus),
    .rdata(rdata),
    .loop_in(loop_in),
    .p_only(p_only)
  );

  // Compare and count
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One-cycle register write
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus <= {1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    bus <= '0;
  endtask : wr_reg
  // Read; data stand in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    bus <= {1'b0, 1'b1, a, 16'h0000};
    @(posedge ref_clk);
    bus <= '0;
    #1 d = rdata;
  endtask : rd_reg
  // One loop update, p_only sampled one cycle later
  task automatic upd(input logic [15:0] t, s, a, e, input logic pm,
                     output logic [15:0] p);
    @(posedge ref_clk);
    loop_in <= {t, s, a, e, pm, 1'b1};
    @(posedge ref_clk);
    loop_in.update <= 1'b0;
    #1 p = {15'h0000, p_only};
  endtask : upd
  task automatic t_defaults;
    logic [15:0] v;
    rd_reg(4'h0, v); chk("selector", v, 16'h0000);
    rd_reg(4'h1, v); chk("torque level", v, 16'h00C8);
    for (int i = 2; i < 5; i++) begin
      rd_reg(4'(i), v); chk("level", v, 16'h0000);
    end
    rd_reg(4'h6, v); chk("unmapped", v, 16'h0000);
    rd_reg(4'h5, v); chk("status", v, 16'h0000);
    $display("test defaults done");
  endtask : t_defaults
  task automatic t_torque;
    logic [15:0] p, v;
    upd(16'h00C9, 16'h0, 16'h0, 16'h0, 1'b0, p); chk("p", p, 1);
    rd_reg(4'h5, v); chk("status", v, 16'h0003);
    upd(16'h00C8, 16'h0, 16'h0, 16'h0, 1'b0, p); chk("p", p, 0);
    upd(16'hFF37, 16'h0, 16'h0, 16'h0, 1'b0, p); chk("p", p, 1);
    wr_reg(4'h1, 16'h0321);
    rd_reg(4'h1, v); chk("torque max", v, 16'h0320);
    $display("test torque done");
  endtask : t_torque
  task automatic t_others;
    logic [15:0] p, v;
    logic [15:0] q [4];
    logic [15:0] mx [4] = '{16'h0, 16'h2710, 16'h7530, 16'h2710};
    for (int i = 1; i < 4; i++) begin
      wr_reg(4'h0, 16'(i));
      rd_reg(4'h0, v); chk("selector", v, 16'(i));
      wr_reg(4'(i + 1), 16'hFFFF);
      rd_reg(4'(i + 1), v); chk("level max", v, mx[i]);
      wr_reg(4'(i + 1), 16'h0064);
      q = '{default: 16'h0};
      q[i] = 16'h0065;
      upd(q[0], q[1], q[2], q[3], 1'b1, p); chk("p", p, 1);
      q[i] = 16'h0064;
      upd(q[0], q[1], q[2], q[3], 1'b1, p); chk("p", p, 0);
    end
    $display("test other conditions done");
  endtask : t_others
  task automatic t_posmode;
    logic [15:0] p, v;
    upd(16'h0, 16'h0, 16'h0, 16'h03E8, 1'b0, p); chk("p", p, 0);
    upd(16'h0, 16'h0, 16'h0, 16'h03E8, 1'b1, p); chk("p", p, 1);
    wr_reg(4'h4, 16'h03E8);
    rd_reg(4'h5, v); chk("status", v, 16'h0001);
    upd(16'h0, 16'h0, 16'h0, 16'h03E8, 1'b1, p); chk("p", p, 0);
    $display("test position mode done");
  endtask : t_posmode
  task automatic t_off;
    logic [15:0] p, v;
    for (int c = 4; c < 8; c++) begin
      wr_reg(4'h0, 16'(c));
      rd_reg(4'h0, v); chk("selector", v, 16'(c));
      upd(16'h7FFF, 16'h7FFF, 16'h7FFF, 16'h7FFF, 1'b1, p);
      chk("p", p, 0);
    end
    wr_reg(4'h0, 16'h0000);
    upd(16'h7FFF, 16'h0, 16'h0, 16'h0, 1'b1, p); chk("p", p, 1);
    $display("test disabled done");
  endtask : t_off
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_defaults();
    t_torque();
    t_others();
    t_posmode();
    t_off();
    tally_and_finish();
  end
endmodule : pmsw_core_tb
